// *** rtl/otpcfg_pkg.sv ***
/*
  Constants for the one-time-programmable option loader: the normal and programming address maps,
  the option byte layout, the erased values and the oscillation wait counts.
  Assumes a single 100 MHz clock and an 8-bit array of 16 Kbytes of code plus an option area.
*/
// Function
// - Programming addresses 4000-7FFF reach top program quarter.
// - Option bit 0 enables power-on reset.
// - Option bit 1 selects dual-clock operation.
// - Option bit 2 enables reset pin output.
// - Option bits 5 and 4 select oscillation wait.
// - Option bits read 1 when erased.
// - Vacant option bits read 1 unless zeroed.
// - Electronic signature read mode is not supported.
// - Decode 64K space: I/O, data, program, vectors.
// - Software reads options at BFF0 through BFF6.
package otpcfg_pkg;
   // Program array geometry: 16 Kbytes of code, then sixteen option cells above it, so that
   // option bytes never share a cell with the vectors at the top of the code area.
   localparam int          ARRAY_WORDS    = 16400;
   localparam int          ARRAY_AW       = 15;
   localparam logic [7:0]  ERASED_BYTE    = 8'h0_0FF;
   // Programmer-side window of the program area and the option bytes.
   localparam logic [14:0] PRG_CODE_LO    = 15'h0_4000;
   localparam logic [14:0] PRG_CODE_HI    = 15'h0_7FFF;
   localparam logic [14:0] PRG_OPT_LO     = 15'h0_3FF0;
   localparam logic [14:0] PRG_OPT_HI     = 15'h0_3FF5;
   // Normal-mode memory map.
   localparam logic [15:0] IO_HI          = 16'h0_007F;
   localparam logic [15:0] DATA_HI        = 16'h0_047F;
   localparam logic [15:0] CODE_LO        = 16'h0_C000;
   localparam logic [15:0] OPT_LO         = 16'h0_BFF0;
   localparam logic [15:0] OPT_HI         = 16'h0_BFF6;
   localparam logic [15:0] VECT_LO        = 16'h0_FFC0;
   // Array index of the first option byte; option byte k sits at OPT_INDEX + k.
   localparam logic [14:0] OPT_INDEX      = 15'h0_4000;
   localparam logic [2:0]  OPT_COUNT      = 3'h0_6;
   // Field positions within the first option byte.
   localparam int          BIT_POR        = 0;
   localparam int          BIT_DUAL       = 1;
   localparam int          BIT_RSTOUT     = 2;
   localparam int          BIT_WAIT_LO    = 4;
   localparam int          BIT_WAIT_HI    = 5;
   // Oscillation wait times in microseconds, by field code, and their clock counts at 100 MHz.
   localparam int          CLK_MHZ        = 100;
   localparam int          WAIT_US0       = 4;
   localparam int          WAIT_US1       = 16;
   localparam int          WAIT_US2       = 64;
   localparam int          WAIT_US3       = 256;
   localparam logic [15:0] WAIT_CYC0      = 16'(WAIT_US0 * CLK_MHZ);
   localparam logic [15:0] WAIT_CYC1      = 16'(WAIT_US1 * CLK_MHZ);
   localparam logic [15:0] WAIT_CYC2      = 16'(WAIT_US2 * CLK_MHZ);
   localparam logic [15:0] WAIT_CYC3      = 16'(WAIT_US3 * CLK_MHZ);
   // Region codes reported by the address decoder.
   localparam logic [2:0]  REG_IO         = 3'h0_0;
   localparam logic [2:0]  REG_DATA       = 3'h0_1;
   localparam logic [2:0]  REG_CODE       = 3'h0_2;
   localparam logic [2:0]  REG_OPT        = 3'h0_3;
   localparam logic [2:0]  REG_VECT       = 3'h0_4;
   localparam logic [2:0]  REG_NONE       = 3'h0_7;
endpackage

// *** rtl/otpcfg_array.sv ***
/*
  Program and option storage: a byte-wide array with one write port and one registered read port.
  Assumes the caller never reads and writes the same cycle with conflicting intent.
*/
module otpcfg_array (
   // Clock and freeze.
   input  wire logic        clk,
   input  wire logic        clkEn,
   // Write port.
   input  wire logic        wrEn,
   input  wire logic [14:0] wrAddr,
   input  wire logic [7:0]  wrData,
   // Read port.
   input  wire logic [14:0] rdAddr,
   output logic      [7:0]  rdData_ff
);
   // The array starts erased, so every cell reads as all ones until programmed.
   logic [7:0] mem [0:otpcfg_pkg::ARRAY_WORDS-1];

   initial begin
      for (int i = 0; i < otpcfg_pkg::ARRAY_WORDS; i++) begin
         mem[i] = otpcfg_pkg::ERASED_BYTE;
      end
   end

   // Programming can only clear bits, as in a real one-time cell, so a 1 leaves a bit erased.
   always_ff @(posedge clk) begin
      if (clkEn && wrEn) begin
         mem[wrAddr] <= mem[wrAddr] & wrData;
      end
   end

   // Registered read data.
   always_ff @(posedge clk) begin
      if (clkEn) begin
         rdData_ff <= mem[rdAddr];
      end
   end
endmodule // otpcfg_array

// *** rtl/otpcfg_top.sv ***
/*
  Option loader top: programming-mode access to the array, normal-mode decode and option readback,
  and the reset-time load of the option bytes into held settings.
  Assumes programming strobes come from pins and are synchronised here; the CPU side is on clk.
*/
module otpcfg_top (
   // Clock, reset and freeze.
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        clkEn,
   // Programming mode pins from the socket adapter.
   input  wire logic        progMode,
   input  wire logic [14:0] progAddr,
   input  wire logic [7:0]  progData,
   input  wire logic        progWrite,
   input  wire logic        progRead,
   output logic      [7:0]  progRdData_ff,
   output logic             progRdValid_ff,
   // Normal-mode CPU read port.
   input  wire logic        cpuRead,
   input  wire logic [15:0] cpuAddr,
   output logic      [7:0]  cpuRdData_ff,
   output logic             cpuRdValid_ff,
   output logic      [2:0]  cpuRegion_ff,
   // Decoded option settings.
   output logic             porEnable_ff,
   output logic             dualClock_ff,
   output logic             rstPinOutEn_ff,
   output logic      [1:0]  oscWaitSel_ff,
   output logic      [15:0] oscWaitCycles_ff,
   output logic      [7:0]  port0PullupEn_ff,
   output logic      [7:0]  port1PullupEn_ff,
   output logic             optLoaded_ff
);
   // Loader states, one-hot.
   typedef enum logic [3:0] {
      LD_IDLE = 4'b0001,
      LD_REQ  = 4'b0010,
      LD_CAP  = 4'b0100,
      LD_DONE = 4'b1000
   } otpcfg_ld_type;

   // Two-stage synchronisers for the pin-side controls and buses.
   logic        progModeS1_ff, progModeS2_ff;
   logic        progWrS1_ff,   progWrS2_ff,  progWrOld_ff;
   logic        progRdS1_ff,   progRdS2_ff,  progRdOld_ff;
   logic [14:0] progAddrS1_ff, progAddrS2_ff;
   logic [7:0]  progDataS1_ff, progDataS2_ff;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         progModeS1_ff <= 1'b0;
         progModeS2_ff <= 1'b0;
         progWrS1_ff   <= 1'b0;
         progWrS2_ff   <= 1'b0;
         progWrOld_ff  <= 1'b0;
         progRdS1_ff   <= 1'b0;
         progRdS2_ff   <= 1'b0;
         progRdOld_ff  <= 1'b0;
         progAddrS1_ff <= '0;
         progAddrS2_ff <= '0;
         progDataS1_ff <= '0;
         progDataS2_ff <= '0;
      end else if (clkEn) begin
         progModeS1_ff <= progMode;
         progModeS2_ff <= progModeS1_ff;
         progWrS1_ff   <= progWrite;
         progWrS2_ff   <= progWrS1_ff;
         progWrOld_ff  <= progWrS2_ff;
         progRdS1_ff   <= progRead;
         progRdS2_ff   <= progRdS1_ff;
         progRdOld_ff  <= progRdS2_ff;
         progAddrS1_ff <= progAddr;
         progAddrS2_ff <= progAddrS1_ff;
         progDataS1_ff <= progData;
         progDataS2_ff <= progDataS1_ff;
      end
   end

   // Strobe edges, taken only after both synchroniser stages.
   logic progWrPulse, progRdPulse;
   assign progWrPulse = progModeS2_ff && progWrS2_ff && !progWrOld_ff;
   assign progRdPulse = progModeS2_ff && progRdS2_ff && !progRdOld_ff;

   // Programmer address mapping: the code window folds onto the code cells of the array, and
   // the option window onto the option cells above them, so writing an option never touches
   // a vector byte that happens to share the low address bits.
   logic        progInCode, progInOpt;
   logic [14:0] progIndex;
   assign progInCode = (progAddrS2_ff >= otpcfg_pkg::PRG_CODE_LO);
   assign progInOpt  = (progAddrS2_ff >= otpcfg_pkg::PRG_OPT_LO)
                    && (progAddrS2_ff <= otpcfg_pkg::PRG_OPT_HI);
   assign progIndex  = progInOpt ? (otpcfg_pkg::OPT_INDEX + 15'(progAddrS2_ff[3:0]))
                                 : {1'b0, progAddrS2_ff[13:0]};

   // Loader state and option capture registers.
   otpcfg_ld_type ldState_ff;
   logic [1:0]    ldIdx_ff;
   logic [7:0]    optByte0_ff;

   // Array read address is shared; the loader owns it until options are held.
   logic        cpuInCode, cpuInOpt;
   logic [14:0] cpuIndex, rdAddr;
   logic [7:0]  rdData_ff;
   assign cpuInCode = (cpuAddr >= otpcfg_pkg::CODE_LO);
   assign cpuInOpt  = (cpuAddr >= otpcfg_pkg::OPT_LO) && (cpuAddr <= otpcfg_pkg::OPT_HI);
   assign cpuIndex  = cpuInOpt ? (otpcfg_pkg::OPT_INDEX + 15'(cpuAddr[3:0]))
                               : {1'b0, cpuAddr[13:0]};

   always_comb begin
      if (ldState_ff != LD_DONE) begin
         rdAddr = otpcfg_pkg::OPT_INDEX + 15'(ldIdx_ff);
      end else if (progModeS2_ff) begin
         rdAddr = progIndex;
      end else begin
         rdAddr = cpuIndex;
      end
   end

   otpcfg_array u_array (
      .clk       (clk),
      .clkEn     (clkEn),
      .wrEn      (progWrPulse && (progInCode || progInOpt)),
      .wrAddr    (progIndex),
      .wrData    (progDataS2_ff),
      .rdAddr    (rdAddr),
      .rdData_ff (rdData_ff)
   );

   // Reset-time load: three option bytes are read once, then the state rests until reset.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ldState_ff <= LD_IDLE;
         ldIdx_ff   <= 2'h0_0;
      end else if (clkEn) begin
         case (ldState_ff)
            LD_IDLE: ldState_ff <= LD_REQ;
            LD_REQ:  ldState_ff <= LD_CAP;
            LD_CAP: begin
               if (ldIdx_ff == 2'h0_2) begin
                  ldState_ff <= LD_DONE;
               end else begin
                  ldIdx_ff   <= ldIdx_ff + 2'h0_1;
                  ldState_ff <= LD_REQ;
               end
            end
            LD_DONE: ldState_ff <= LD_DONE;
            default: ldState_ff <= LD_IDLE;
         endcase
      end
   end

   // Decoded settings; before the load they hold the erased meaning of all ones.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         optByte0_ff      <= otpcfg_pkg::ERASED_BYTE;
         porEnable_ff     <= 1'b1;
         dualClock_ff     <= 1'b1;
         rstPinOutEn_ff   <= 1'b1;
         oscWaitSel_ff    <= 2'h0_3;
         oscWaitCycles_ff <= otpcfg_pkg::WAIT_CYC3;
         port0PullupEn_ff <= 8'h0_00;
         port1PullupEn_ff <= 8'h0_00;
         optLoaded_ff     <= 1'b0;
      end else if (clkEn && ldState_ff == LD_CAP) begin
         case (ldIdx_ff)
            2'h0_0: begin
               optByte0_ff    <= rdData_ff;
               porEnable_ff   <= rdData_ff[otpcfg_pkg::BIT_POR];
               dualClock_ff   <= rdData_ff[otpcfg_pkg::BIT_DUAL];
               rstPinOutEn_ff <= rdData_ff[otpcfg_pkg::BIT_RSTOUT];
               oscWaitSel_ff  <= {rdData_ff[otpcfg_pkg::BIT_WAIT_HI],
                                  rdData_ff[otpcfg_pkg::BIT_WAIT_LO]};
               case ({rdData_ff[otpcfg_pkg::BIT_WAIT_HI], rdData_ff[otpcfg_pkg::BIT_WAIT_LO]})
                  2'h0_0:  oscWaitCycles_ff <= otpcfg_pkg::WAIT_CYC0;
                  2'h0_1:  oscWaitCycles_ff <= otpcfg_pkg::WAIT_CYC1;
                  2'h0_2:  oscWaitCycles_ff <= otpcfg_pkg::WAIT_CYC2;
                  default: oscWaitCycles_ff <= otpcfg_pkg::WAIT_CYC3;
               endcase
            end
            2'h0_1:  port0PullupEn_ff <= ~rdData_ff;
            default: begin
               port1PullupEn_ff <= ~rdData_ff;
               optLoaded_ff     <= 1'b1;
            end
         endcase
      end
   end

   // Programmer read: two cycles after the synchronised strobe edge the array data stand.
   // There is no signature mode, so every address simply returns array contents.
   logic progRdDly_ff;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         progRdDly_ff   <= 1'b0;
         progRdValid_ff <= 1'b0;
         progRdData_ff  <= otpcfg_pkg::ERASED_BYTE;
      end else if (clkEn) begin
         progRdDly_ff   <= progRdPulse && (ldState_ff == LD_DONE);
         progRdValid_ff <= progRdDly_ff;
         if (progRdDly_ff) begin
            progRdData_ff <= rdData_ff;
         end
      end
   end

   // Normal-mode decode of the 64 Kbyte space; region is reported with each read.
   logic [2:0] cpuRegion;
   always_comb begin
      if (cpuAddr <= otpcfg_pkg::IO_HI) begin
         cpuRegion = otpcfg_pkg::REG_IO;
      end else if (cpuAddr <= otpcfg_pkg::DATA_HI) begin
         cpuRegion = otpcfg_pkg::REG_DATA;
      end else if (cpuInOpt) begin
         cpuRegion = otpcfg_pkg::REG_OPT;
      end else if (cpuAddr >= otpcfg_pkg::VECT_LO) begin
         cpuRegion = otpcfg_pkg::REG_VECT;
      end else if (cpuInCode) begin
         cpuRegion = otpcfg_pkg::REG_CODE;
      end else begin
         cpuRegion = otpcfg_pkg::REG_NONE;
      end
   end

   // CPU reads of code or option space return array data two cycles later; other regions
   // belong to other blocks and return all ones here. Reads are ignored in programming mode.
   logic       cpuRdDly_ff, cpuHit_ff;
   logic [2:0] cpuRegDly_ff;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpuRdDly_ff   <= 1'b0;
         cpuHit_ff     <= 1'b0;
         cpuRegDly_ff  <= otpcfg_pkg::REG_NONE;
         cpuRdValid_ff <= 1'b0;
         cpuRdData_ff  <= otpcfg_pkg::ERASED_BYTE;
         cpuRegion_ff  <= otpcfg_pkg::REG_NONE;
      end else if (clkEn) begin
         cpuRdDly_ff   <= cpuRead && !progModeS2_ff && (ldState_ff == LD_DONE);
         cpuHit_ff     <= cpuInCode || cpuInOpt;
         cpuRegDly_ff  <= cpuRegion;
         cpuRdValid_ff <= cpuRdDly_ff;
         if (cpuRdDly_ff) begin
            cpuRdData_ff <= cpuHit_ff ? rdData_ff : otpcfg_pkg::ERASED_BYTE;
            cpuRegion_ff <= cpuRegDly_ff;
         end
      end
   end
endmodule // otpcfg_top

// *** dv/otpcfg_monitor.sv ***
/*
  Port checker for the option loader top.
  Assumes one clock, clkEn held high and an asynchronous active-high reset.
*/
module otpcfg_monitor (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        reset,
   // Request side.
   input wire logic        progMode,
   input wire logic        cpuRead,
   input wire logic [15:0] cpuAddr,
   // Answers.
   input wire logic        progRdValid_ff,
   input wire logic        cpuRdValid_ff,
   input wire logic [2:0]  cpuRegion_ff,
   // Held settings.
   input wire logic        porEnable_ff,
   input wire logic        dualClock_ff,
   input wire logic        rstPinOutEn_ff,
   input wire logic [1:0]  oscWaitSel_ff,
   input wire logic [15:0] oscWaitCycles_ff,
   input wire logic [7:0]  port0PullupEn_ff,
   input wire logic [7:0]  port1PullupEn_ff,
   input wire logic        optLoaded_ff
);
   // Expected region of a normal-mode address, vectors checked before code.
   function automatic logic [2:0] regionOf(logic [15:0] a);
      if (a <= otpcfg_pkg::IO_HI) return otpcfg_pkg::REG_IO;
      if (a <= otpcfg_pkg::DATA_HI) return otpcfg_pkg::REG_DATA;
      if (a >= otpcfg_pkg::VECT_LO) return otpcfg_pkg::REG_VECT;
      if (a >= otpcfg_pkg::CODE_LO) return otpcfg_pkg::REG_CODE;
      if (a >= otpcfg_pkg::OPT_LO && a <= otpcfg_pkg::OPT_HI) return otpcfg_pkg::REG_OPT;
      return otpcfg_pkg::REG_NONE;
   endfunction
   // Mode pin low long enough to pass the two-flop synchroniser.
   sequence normalQuiet;
      !progMode [*4];
   endsequence
   // Mode pin high long enough that no CPU read can be in flight.
   sequence progSettled;
      progMode [*6];
   endsequence
   read_answer_a: assert property (@(posedge clk) disable iff (reset)
      normalQuiet ##0 (cpuRead && optLoaded_ff) |-> ##2 (cpuRdValid_ff
      && cpuRegion_ff == $past(regionOf(cpuAddr), 2))) else $error("cpu read answer wrong");
   valid_cause_a: assert property (@(posedge clk) disable iff (reset)
      cpuRdValid_ff |-> $past(cpuRead, 2)) else $error("cpu valid without request");
   prog_block_a: assert property (@(posedge clk) disable iff (reset)
      progSettled |-> !cpuRdValid_ff) else $error("cpu answered in programming mode");
   wait_count_a: assert property (@(posedge clk) disable iff (reset)
      optLoaded_ff |-> oscWaitCycles_ff == (oscWaitSel_ff == 2'h0 ? otpcfg_pkg::WAIT_CYC0 :
      oscWaitSel_ff == 2'h1 ? otpcfg_pkg::WAIT_CYC1 : oscWaitSel_ff == 2'h2 ?
      otpcfg_pkg::WAIT_CYC2 : otpcfg_pkg::WAIT_CYC3)) else $error("wait count mismatch");
   opts_held_a: assert property (@(posedge clk) disable iff (reset)
      optLoaded_ff && $past(optLoaded_ff) |-> $stable({porEnable_ff, dualClock_ff,
      rstPinOutEn_ff, oscWaitSel_ff, port0PullupEn_ff, port1PullupEn_ff}))
      else $error("settings moved between resets");
   load_time_a: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> !optLoaded_ff [*7] ##1 optLoaded_ff) else $error("load time wrong");
   erased_reset_a: assert property (@(posedge clk)
      reset && $past(reset) |-> porEnable_ff && dualClock_ff && rstPinOutEn_ff
      && oscWaitSel_ff == 2'h3 && port0PullupEn_ff == 8'h00 && port1PullupEn_ff == 8'h00
      && !optLoaded_ff) else $error("reset values not erased meaning");
   prog_pulse_a: assert property (@(posedge clk) disable iff (reset)
      progRdValid_ff |-> optLoaded_ff ##1 !progRdValid_ff) else $error("prog valid not a pulse");
endmodule // otpcfg_monitor

bind otpcfg_top otpcfg_monitor u_mon (.clk(clk), .reset(reset), .progMode(progMode),
   .cpuRead(cpuRead), .cpuAddr(cpuAddr), .progRdValid_ff(progRdValid_ff),
   .cpuRdValid_ff(cpuRdValid_ff), .cpuRegion_ff(cpuRegion_ff), .porEnable_ff(porEnable_ff),
   .dualClock_ff(dualClock_ff), .rstPinOutEn_ff(rstPinOutEn_ff), .oscWaitSel_ff(oscWaitSel_ff),
   .oscWaitCycles_ff(oscWaitCycles_ff), .port0PullupEn_ff(port0PullupEn_ff),
   .port1PullupEn_ff(port1PullupEn_ff), .optLoaded_ff(optLoaded_ff));

// *** dv/otpcfg_programmer.sv ***
/*
  Behavioural programmer on the socket adapter pins.
  Assumes the loader synchronises the pins, so setup and strobe widths are in whole clocks.
*/
module otpcfg_programmer (
   // Clock.
   input wire logic        clk,
   // Adapter pins.
   output logic            progMode,
   output logic     [14:0] progAddr,
   output logic     [7:0]  progData,
   output logic            progWrite,
   output logic            progRead,
   // Read answer.
   input wire logic [7:0]  progRdData_ff,
   input wire logic        progRdValid_ff
);
   timeunit 1ns;
   timeprecision 100ps;
   // Pins idle with strobes low; data shows a changing pattern when not qualified.
   initial begin
      {progMode, progWrite, progRead} = 3'h0;
      progAddr = 15'h0_0000;
      progData = 8'h55;
   end
   // One byte write; a 1 leaves a cell bit erased, only 0 bits program.
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      @(posedge clk) #1 progAddr = a;
      progData = d;
      repeat (3) @(posedge clk);
      #1 progWrite = 1'b1;
      repeat (4) @(posedge clk);
      #1 progWrite = 1'b0;
      progData = ~d;
      repeat (3) @(posedge clk);
   endtask
   // One byte read; the strobe is held until the valid pulse is sampled.
   task automatic rd(input logic [14:0] a, output logic [7:0] d, output bit ok);
      ok = 0;
      @(posedge clk) #1 progAddr = a;
      repeat (3) @(posedge clk);
      #1 progRead = 1'b1;
      for (int i = 0; i < 12 && !ok; i++) begin
         @(posedge clk) #1 ok = (progRdValid_ff === 1'b1);
      end
      d = progRdData_ff;
      progRead = 1'b0;
      repeat (3) @(posedge clk);
   endtask
endmodule // otpcfg_programmer

// *** dv/otpcfg_top_tb.sv ***
/*
  Self-checking bench for the option loader top.
  Assumes the array powers up erased and keeps its contents across reset.
*/
module otpcfg_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, reset = 1, cpuRead = 0; // Bench-driven controls.
   logic [15:0] cpuAddr = 16'h0_0000; // CPU address.
   logic progMode, progWrite, progRead, progRdValid_ff, cpuRdValid_ff; // Pins and pulses.
   logic porEnable_ff, dualClock_ff, rstPinOutEn_ff, optLoaded_ff; // Held flags.
   logic [14:0] progAddr; // Programmer address.
   logic [7:0] progData, progRdData_ff, cpuRdData_ff, p0Pu, p1Pu; // Bytes.
   logic [2:0] cpuRegion_ff; // Region of last read.
   logic [1:0] oscWaitSel_ff; // Wait code.
   logic [15:0] oscWaitCycles_ff; // Wait count.
   int n_fail = 0, compares = 0, cycles = 0; // Tallies.
   logic [7:0] optImg [7] = '{8'hEA, 8'h5A, 8'hC3, 8'hFF, 8'hFF, 8'hFF, 8'hFF}; // Image.
   always #5 clk = ~clk; // 100 MHz.
   // The freeze input stays high: the checker's cycle counts assume every edge is enabled.
   otpcfg_top DUT (.clk(clk), .reset(reset), .clkEn(1'b1), .progMode(progMode),
      .progAddr(progAddr), .progData(progData), .progWrite(progWrite), .progRead(progRead),
      .progRdData_ff(progRdData_ff), .progRdValid_ff(progRdValid_ff), .cpuRead(cpuRead),
      .cpuAddr(cpuAddr), .cpuRdData_ff(cpuRdData_ff), .cpuRdValid_ff(cpuRdValid_ff),
      .cpuRegion_ff(cpuRegion_ff), .porEnable_ff(porEnable_ff), .dualClock_ff(dualClock_ff),
      .rstPinOutEn_ff(rstPinOutEn_ff), .oscWaitSel_ff(oscWaitSel_ff),
      .oscWaitCycles_ff(oscWaitCycles_ff), .port0PullupEn_ff(p0Pu), .port1PullupEn_ff(p1Pu),
      .optLoaded_ff(optLoaded_ff));
   otpcfg_programmer prog (.clk(clk), .progMode(progMode), .progAddr(progAddr),
      .progData(progData), .progWrite(progWrite), .progRead(progRead),
      .progRdData_ff(progRdData_ff), .progRdValid_ff(progRdValid_ff));
   // Compares one result; the four-state equality keeps unknowns from matching.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Settings as a word: por, dual, rst out, wait code, then the port 0 pull-up byte.
   function automatic logic [15:0] sets();
      return {1'b0, porEnable_ff, dualClock_ff, rstPinOutEn_ff, 2'b00, oscWaitSel_ff, p0Pu};
   endfunction
   // Resets for 16 cycles, checks the erased meaning, then waits for the load.
   task automatic doReset();
      @(posedge clk) #1 reset = 1;
      repeat (16) @(posedge clk);
      chk(sets(), 16'h0_7300);
      chk({8'h00, p0Pu}, 16'h0_0000);
      #1 reset = 0;
      for (int i = 0; i < 20 && optLoaded_ff !== 1'b1; i++) @(posedge clk);
      #1;
   endtask
   // One CPU read, checked for data and region.
   task automatic cpuRd(input logic [15:0] a, input logic [7:0] d, input logic [2:0] r);
      @(posedge clk) #1 cpuRead = 1;
      cpuAddr = a;
      @(posedge clk) #1 cpuRead = 0;
      for (int i = 0; i < 4 && cpuRdValid_ff !== 1'b1; i++) @(posedge clk) #1;
      chk({7'h00, cpuRdValid_ff, cpuRdData_ff}, {8'h01, d});
      chk({13'h0000, cpuRegion_ff}, {13'h0000, r});
   endtask
   // Programs options and code, then checks that the settings word does not move before a reset.
   task automatic t_program();
      logic [7:0] d;
      bit ok;
      prog.progMode = 1;
      repeat (6) @(posedge clk);
      for (int k = 0; k < 6; k++) prog.wr(15'h3FF0 + 15'(k), optImg[k]);
      prog.wr(15'h0_4000, 8'hF0);
      prog.wr(15'h0_4000, 8'h3C);
      prog.wr(15'h0_7FFF, 8'hA5);
      prog.rd(15'h0_4000, d, ok);
      chk({7'h00, ok, d}, 16'h0_0130);
      prog.rd(15'h0_7FFF, d, ok);
      chk({7'h00, ok, d}, 16'h0_01A5);
      prog.rd(15'h0_7FF0, d, ok);
      chk({7'h00, ok, d}, 16'h0_01FF);
      prog.rd(15'h0_3FF0, d, ok);
      chk({7'h00, ok, d}, 16'h0_01EA);
      chk(sets(), 16'h0_7300);
      #1 prog.progMode = 0;
      $display("test t_program done");
   endtask
   // Reloads after reset and checks decoding and normal-mode readback.
   task automatic t_decode();
      doReset();
      chk(sets(), 16'h0_22A5);
      chk({8'h00, p1Pu}, 16'h0_003C);
      chk(oscWaitCycles_ff, otpcfg_pkg::WAIT_CYC2);
      repeat (5) @(posedge clk);
      for (int k = 0; k < 7; k++) cpuRd(16'hBFF0 + 16'(k), optImg[k], 3'h3);
      cpuRd(16'h0_C000, 8'h30, 3'h2);
      cpuRd(16'h0_FFFF, 8'hA5, 3'h4);
      cpuRd(16'h0_FFF0, 8'hFF, 3'h4);
      cpuRd(16'h0_0010, 8'hFF, 3'h0);
      cpuRd(16'h0_0100, 8'hFF, 3'h1);
      cpuRd(16'h0_8000, 8'hFF, 3'h7);
      $display("test t_decode done");
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // A hang counts as a mismatch; the tests need well under 3000 cycles.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         stop_test();
      end
   end
   // Main sequence.
   initial begin
      doReset();
      t_program();
      t_decode();
      stop_test();
   end
endmodule // otpcfg_top_tb
